/* File: verif/sfam_bus_peer.sv */
// sfam_bus_peer: another master on the two-wire bus, open-drain
// assumes: lines pulled up; the device may stretch scl
`timescale 1ns/1ps
`default_nettype none
module sfam_bus_peer (
   // clock and lines
   input wire logic link_clk,
   input wire logic scl,
   input wire logic sda,
   // pull-downs
   output logic scl_low,
   output logic sda_low
);
   int nbit = 0;
   logic stall_err = 1'b0;
   initial
   begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge link_clk);
   endtask
   // release scl; a stretch is waited out, bounded
   task automatic rise();
      int k;
      scl_low <= 1'b0;
      k = 0;
      do
      begin
         @(posedge link_clk);
         k++;
      end
      while (scl !== 1'b1 && k < 4000);
      if (scl !== 1'b1)
         stall_err <= 1'b1;
      hold(6);
   endtask
   task automatic bit_cyc(input logic b, output logic s);
      sda_low <= !b;
      hold(4);
      rise();
      s = sda;
      scl_low <= 1'b1;
   endtask
   task automatic start();
      // a stall from the last frame must end first, or the START is lost
      rise();
      sda_low <= 1'b1;
      hold(4);
      scl_low <= 1'b1;
      nbit = 0;
   endtask
   // msb first, ninth slot released for the ack
   task automatic send_byte(input logic [7:0] d, output logic acked);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bit_cyc(d[i], s);
         nbit++;
      end
      bit_cyc(1'b1, s);
      acked = !s;
   endtask
   task automatic stop();
      sda_low <= 1'b1;
      hold(4);
      rise();
      sda_low <= 1'b0;
      hold(8);
   endtask
endmodule
`default_nettype wire

/* File: verif/sfam_props.sv */
// sfam_props: port checks for sfam_top
// assumes: bound to sfam_top
`timescale 1ns/1ps
`default_nettype none
module sfam_props (
   // clocks and reset
   input wire logic ref_clk,
   input wire logic link_clk,
   input wire logic rst,
   // register bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   // pins and engine
   input wire logic scl_o,
   input wire logic scl_oe,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic gen_start_done,
   input wire logic gen_stop_done,
   input wire logic start_request,
   input wire logic stop_request
);
   // ==========
   // recent write window
   logic [2:0] wr_cnt_q;
   always_ff @(posedge ref_clk or posedge rst)
      if (rst)
         wr_cnt_q <= 3'h0;
      else if (hsel && hready && htrans[1] && hwrite)
         wr_cnt_q <= 3'h4;
      else if (wr_cnt_q != 3'h0)
         wr_cnt_q <= wr_cnt_q - 3'h1;
   a_resp_okay: assert property (@(posedge ref_clk) disable iff (rst) hresp == 1'b0)
      else $error("response not okay");
   a_read_wait: assert property (@(posedge ref_clk) disable iff (rst)
      (hsel && hready && htrans[1] && !hwrite) |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
   a_write_zero: assert property (@(posedge ref_clk) disable iff (rst)
      (hsel && hready && htrans[1] && hwrite) |=> hreadyout) else $error("write stalled");
   a_start_drop: assert property (@(posedge ref_clk) disable iff (rst)
      gen_start_done |=> !start_request) else $error("start request stays");
   a_stop_drop: assert property (@(posedge ref_clk) disable iff (rst)
      gen_stop_done |=> !stop_request) else $error("stop request stays");
   a_scl_pull: assert property (@(posedge ref_clk) disable iff (rst)
      scl_oe |-> !scl_o) else $error("scl driven high");
   a_scl_sw_release: assert property (@(posedge ref_clk) disable iff (rst)
      $fell(scl_oe) |-> wr_cnt_q != 3'h0) else $error("scl released without write");
   a_sda_ack_low: assert property (@(posedge link_clk) disable iff (rst)
      sda_oe |-> !sda_o) else $error("sda driven high");
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// tb: self-checking bench for sfam_top, AHB master plus bus peer
// assumes: reads checked by a monitor against a queue of notes
`timescale 1ns/1ps
`default_nettype none
module tb;
   import sfam_pkg::*;
   logic ref_clk, link_clk, rst, hsel, hwrite, hreadyout, hresp, scl_o, scl_oe, sda_o, sda_oe;
   logic tx_one, start_request, stop_request, p_scl, p_sda, rd_ph, acked, hit;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [4:0] eng;
   logic [6:0] a;
   logic [14:0] row;
   logic [31:0] haddr, hwdata, hrdata, seed, m, e;
   logic [63:0] exp_q[$];
   int fail_count = 0, num_checks = 0, n;
   // open-drain lines with pull-ups
   wire scl = !((scl_oe && !scl_o) || p_scl);
   wire sda = !((sda_oe && !sda_o) || p_sda);
   localparam logic [14:0] ROWS [5] = '{15'h34FE, 15'h34FF, 15'h34FC, 15'h34FD, 15'h70E6};
   localparam logic [6:0] ALIST [6] = '{7'h34, 7'h35, 7'h00, 7'h74, 7'h78, 7'h36};
   sfam_top i_dut (.ref_clk, .link_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .scl_i(scl), .scl_o, .scl_oe, .sda_i(sda),
      .sda_o, .sda_oe, .gen_start_done(eng[0]), .gen_stop_done(eng[1]), .cond_scl_low(eng[2]),
      .frame_begin(eng[3]), .data_written(eng[4]), .tx_bit_one(tx_one), .start_request, .stop_request);
   sfam_bus_peer i_peer (.link_clk, .scl, .sda, .scl_low(p_scl), .sda_low(p_sda));
   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   initial
   begin
      link_clk = 1'b0;
      #13;
      forever #40 link_clk = ~link_clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      num_checks++;
      if (got !== want)
      begin
         fail_count++;
         $display("Error t=%0t got %h exp %h", $time, got, want);
      end
   endtask
   task automatic wait_rdy();
      int k;
      k = 0;
      do
      begin
         @(posedge ref_clk);
         k++;
      end
      while (hreadyout !== 1'b1 && k < 50);
      if (hreadyout !== 1'b1)
      begin
         fail_count++;
         wrap_up();
      end
   endtask
   // single word transfer; a read leaves its expectation in the queue
   task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] d, input logic [31:0] mk);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, ad};
      wait_rdy();
      if (!w)
         exp_q.push_back({mk, d});
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= w ? d : seed;
      seed = lfsr(seed);
      wait_rdy();
   endtask
   task automatic pulse(input int k);
      @(posedge ref_clk);
      eng <= 5'h01 << k;
      @(posedge ref_clk);
      eng <= 5'h00;
   endtask
   // read data compared where it appears
   always @(posedge ref_clk)
   begin
      if (rd_ph === 1'b1 && hreadyout === 1'b1)
      begin
         {m, e} = exp_q.pop_front();
         chk(hrdata & m, e & m);
      end
      if (hreadyout === 1'b1)
         rd_ph <= hsel && htrans[1] && !hwrite;
   end
   initial
   begin
      {hsel, hwrite, htrans, haddr, hwdata, eng, tx_one, rd_ph} = '0;
      hsize = SFAM_HSIZE_WORD;
      seed = 32'h26CF3F25;
      rst = 1'b1;
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      ahb(0, SFAM_CTRL_OFS, 32'h0, 32'hFFFFFFFF);
      ahb(0, SFAM_OWN_OFS, 32'h0, 32'hFFFFFFFF);
      ahb(0, SFAM_MASK_OFS, 32'hFE, 32'hFFFFFFFF);
      ahb(0, 8'h0C, 32'h0, 32'hFFFFFFFF);
      // own START, STOP, then a loss while a restart is pending
      ahb(1, SFAM_CTRL_OFS, 32'h20, 0);
      pulse(0);
      ahb(0, SFAM_CTRL_OFS, 32'hC1, 32'hC1);
      ahb(1, SFAM_CTRL_OFS, 32'h10, 0);
      pulse(1);
      ahb(0, SFAM_CTRL_OFS, 32'h0, 32'h91);
      ahb(1, SFAM_CTRL_OFS, 32'h20, 0);
      pulse(0);
      ahb(1, SFAM_CTRL_OFS, 32'h20, 0);
      pulse(2);
      ahb(0, SFAM_CTRL_OFS, 32'h05, 32'h85);
      ahb(1, SFAM_CTRL_OFS, 32'h0, 0);
      ahb(0, SFAM_CTRL_OFS, 32'h0, 32'h05);
      pulse(4);
      pulse(3);
      ahb(0, SFAM_CTRL_OFS, 32'h40, 32'h40);
      pulse(3);
      ahb(0, SFAM_CTRL_OFS, 32'h0, 32'h40);
      // hardware address match over the mask and general call table
      for (int r = 0; r < 5; r++)
      begin
         row = ROWS[r];
         ahb(1, SFAM_OWN_OFS, {24'h0, row[14:8], row[0]}, 0);
         ahb(1, SFAM_MASK_OFS, {24'h0, row[7:1], 1'b1}, 0);
         for (int k = 0; k < 7; k++)
         begin
            a = k < 6 ? ALIST[k] : seed[6:0];
            seed = lfsr(seed);
            hit = ((a ^ row[14:8]) & row[7:1]) == 7'h0 || (row[0] && a == 7'h0);
            i_peer.start();
            i_peer.send_byte({a, k[0]}, acked);
            chk(acked, hit);
            ahb(0, SFAM_CTRL_OFS, {26'h0, 1'b1, 4'h0, hit}, 32'h21);
            ahb(1, SFAM_CTRL_OFS, 32'h02, 0);
            i_peer.stop();
            ahb(0, SFAM_CTRL_OFS, {27'h0, hit, 3'h0, hit}, 32'h31);
            ahb(1, SFAM_CTRL_OFS, 32'h02, 0);
         end
      end
      // firmware ack with auto ack off
      ahb(1, SFAM_MASK_OFS, 32'hFE, 0);
      i_peer.start();
      fork
         i_peer.send_byte(8'h42, acked);
         begin
            n = 0;
            while (i_peer.nbit != 8 && n < 4000)
            begin
               @(posedge ref_clk);
               n++;
            end
            if (n >= 4000)
            begin
               fail_count++;
               wrap_up();
            end
            repeat (40) @(posedge ref_clk);
            ahb(0, SFAM_CTRL_OFS, 32'h09, 32'h09);
            ahb(1, SFAM_CTRL_OFS, 32'h02, 0);
         end
      join
      chk(acked, 1'b1);
      ahb(0, SFAM_CTRL_OFS, 32'h0, 32'h08);
      i_peer.stop();
      chk(i_peer.stall_err, 1'b0);
      wrap_up();
   end
endmodule
bind sfam_top sfam_props i_props (.ref_clk, .link_clk, .rst, .hsel, .htrans, .hwrite, .hready, .hreadyout,
   .hresp, .scl_o, .scl_oe, .sda_o, .sda_oe, .gen_start_done, .gen_stop_done, .start_request, .stop_request);
`default_nettype wire

/* File: verilog/sfam_link_if.sv */
// sfam_link_if: carries link events and the received byte from the link
// domain to the register domain, and the wanted ack level back.
// assumes: event words stay stable for a whole byte time after their toggle.
`timescale 1ns/1ps
`default_nettype none

interface sfam_link_if;
   import sfam_pkg::*;
   logic [SFAM_EV_N-1:0] ev_tgl;
   logic [7:0] rx_byte;
   logic ack_sample;
   logic ack_drive;

   // link side produces events, core side answers with the ack level
   modport mon (output ev_tgl, output rx_byte, output ack_sample, input ack_drive);
   modport core (input ev_tgl, input rx_byte, input ack_sample, output ack_drive);
endinterface

`default_nettype wire

/* File: verilog/sfam_link_mon.sv */
// sfam_link_mon: watches SCL/SDA, frames bytes,
// reports bus events by toggles,
// and pulls the ack slot low on request.
// assumes: link_clk far faster than SCL.
`timescale 1ns/1ps
`default_nettype none

module sfam_link_mon
   import sfam_pkg::*;
(
   // clock and reset
   input wire logic link_clk,
   input wire logic rst,
   // bus pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // engine bit being sent, link domain
   input wire logic tx_bit_one,
   // to the register domain
   sfam_link_if.mon lnk
);

   logic [1:0] scl_sync_q;
   logic [1:0] sda_sync_q;
   logic [1:0] ackd_sync_q;
   logic scl_prev_q;
   logic sda_prev_q;
   logic [3:0] bit_cnt_q;
   logic [6:0] shift_q;
   logic framed_q;
   logic [7:0] rx_byte_q;
   logic ack_sample_q;
   logic [SFAM_EV_N-1:0] tgl_q;
   logic sda_oe_q;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   // ==========
   // pin synchronisers; only the second stage is looked at
   always_ff @(posedge link_clk or posedge rst)
   begin
      if (rst)
      begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
         ackd_sync_q <= 2'h0;
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end
      else
      begin
         scl_sync_q <= {scl_sync_q[0], scl_i};
         sda_sync_q <= {sda_sync_q[0], sda_i};
         ackd_sync_q <= {ackd_sync_q[0], lnk.ack_drive};
         scl_prev_q <= scl_sync_q[1];
         sda_prev_q <= sda_sync_q[1];
      end
   end

   // conditions: SDA moving while SCL stays high
   assign scl_rise = scl_sync_q[1] & ~scl_prev_q;
   assign scl_fall = ~scl_sync_q[1] & scl_prev_q;
   assign start_det = scl_sync_q[1] & scl_prev_q & sda_prev_q & ~sda_sync_q[1];
   assign stop_det = scl_sync_q[1] & scl_prev_q & ~sda_prev_q & sda_sync_q[1];

   // ==========
   // bit framing, byte capture and event toggles
   always_ff @(posedge link_clk or posedge rst)
   begin
      if (rst)
      begin
         bit_cnt_q <= 4'h0;
         shift_q <= 7'h00;
         framed_q <= 1'b0;
         rx_byte_q <= 8'h00;
         ack_sample_q <= 1'b1;
         tgl_q <= '0;
      end
      else if (start_det)
      begin
         bit_cnt_q <= 4'h0;
         framed_q <= 1'b1;
         tgl_q[SFAM_EV_START] <= ~tgl_q[SFAM_EV_START];
      end
      else if (stop_det)
      begin
         bit_cnt_q <= 4'h0;
         framed_q <= 1'b0;
         tgl_q[SFAM_EV_STOP] <= ~tgl_q[SFAM_EV_STOP];
      end
      else if (scl_rise && framed_q)
      begin
         if (bit_cnt_q == SFAM_ACK_SLOT)
         begin
            // ack slot sampled; value held until the next ack slot
            bit_cnt_q <= 4'h0;
            ack_sample_q <= sda_sync_q[1];
            tgl_q[SFAM_EV_ACK] <= ~tgl_q[SFAM_EV_ACK];
         end
         else
         begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            shift_q <= {shift_q[5:0], sda_sync_q[1]};
            // [RULE_06] sda low against one
            if (tx_bit_one && !sda_sync_q[1])
               tgl_q[SFAM_EV_ARB] <= ~tgl_q[SFAM_EV_ARB];
            if (bit_cnt_q == SFAM_LAST_DATA)
            begin
               rx_byte_q <= {shift_q, sda_sync_q[1]};
               tgl_q[SFAM_EV_BYTE] <= ~tgl_q[SFAM_EV_BYTE];
            end
         end
      end
   end

   // ==========
   // ack drive: from the fall after bit 8 to the fall after bit 9
   always_ff @(posedge link_clk or posedge rst)
   begin
      if (rst)
         sda_oe_q <= 1'b0;
      else if (start_det || stop_det)
         sda_oe_q <= 1'b0;
      else if (scl_fall)
         sda_oe_q <= (bit_cnt_q == SFAM_ACK_SLOT) & framed_q & ackd_sync_q[1];
   end

   // open drain: only ever pulls low
   always_ff @(posedge link_clk or posedge rst)
   begin
      if (rst)
         sda_o <= 1'b0;
      else
         sda_o <= 1'b0;
   end

   assign sda_oe = sda_oe_q;
   assign lnk.ev_tgl = tgl_q;
   assign lnk.rx_byte = rx_byte_q;
   assign lnk.ack_sample = ack_sample_q;

endmodule

`default_nettype wire

/* File: verilog/sfam_pkg.sv */
// sfam_pkg: register map, fields, resets, events
// for the bus flag and address-match block.
// assumes: 32-bit AHB-Lite, one word per register.
`default_nettype none

package sfam_pkg;

   // ==========
   // register byte offsets
   localparam logic [7:0] SFAM_CTRL_OFS = 8'h00;
   localparam logic [7:0] SFAM_OWN_OFS = 8'h04;
   localparam logic [7:0] SFAM_MASK_OFS = 8'h08;

   // ==========
   // bus_control_reg field positions
   localparam int SFAM_ROLE_BIT = 7;
   localparam int SFAM_TX_BIT = 6;
   localparam int SFAM_BEGIN_BIT = 5;
   localparam int SFAM_END_BIT = 4;
   localparam int SFAM_ACK_REQUEST_FLAG_BIT = 3;
   localparam int SFAM_ARB_BIT = 2;
   localparam int SFAM_ACK_BIT = 1;
   localparam int SFAM_IRQ_BIT = 0;

   // ==========
   // reset values
   localparam logic [7:0] SFAM_CTRL_RST = 8'h00;
   localparam logic [6:0] SFAM_OWN_ADDR_RST = 7'h00;
   localparam logic SFAM_GC_RST = 1'b0;
   localparam logic [6:0] SFAM_MASK_RST = 7'h7F;
   localparam logic SFAM_AUTO_ACK_RST = 1'b0;

   // ==========
   // link events carried by toggles
   localparam int SFAM_EV_START = 0;
   localparam int SFAM_EV_STOP = 1;
   localparam int SFAM_EV_BYTE = 2;
   localparam int SFAM_EV_ACK = 3;
   localparam int SFAM_EV_ARB = 4;
   localparam int SFAM_EV_N = 5;

   // ==========
   // bus constants
   localparam logic [2:0] SFAM_HSIZE_WORD = 3'h2;
   localparam logic [3:0] SFAM_ACK_SLOT = 4'h8;
   localparam logic [3:0] SFAM_LAST_DATA = 4'h7;

endpackage

`default_nettype wire

/* File: verilog/sfam_top.sv */
// sfam_top: bus flags and hardware address match,
// registers on AHB-Lite.
// assumes: engine pulses on ref_clk; link events
// via sfam_link_mon on link_clk; word accesses only.
//
// Behaviour
// [RULE_01] role set by own START, cleared by own STOP or arbitration loss
// [RULE_02] transmitter set by START or early data write, else cleared at frame
// [RULE_03] begin seen set on START plus address byte; software clears
// [RULE_04] end set on slave STOP or STOP-caused loss; own STOP clears
// [RULE_05] ack request set per received byte without auto ack; each ack clears
// [RULE_06] arbitration lost: unwanted restart, SCL low at condition, SDA mismatch
// [RULE_07] arbitration lost clears when software clears the interrupt flag
// [RULE_08] ack bit is the inverse of the sampled ack slot
// [RULE_09] interrupt flag set on listed bus events; software clears
// [RULE_10] auto ack: address recognition and hardware acks
// [RULE_11] address bits compared only where the mask holds one
// [RULE_12] general call enable adds the all-zero address
// [RULE_13] SCL held low while the interrupt flag is set
// [RULE_14] unacked address silences slave events until next START
// [RULE_15] mask in bits 7:1 resets to ones, auto ack bit 0 to zero
// [RULE_16] compare the seven address bits, not the direction bit
// [RULE_17] without auto ack no hardware match; firmware acks via request
`timescale 1ns/1ps
`default_nettype none

module sfam_top
   import sfam_pkg::*;
(
   // clocks and reset
   input wire logic ref_clk,
   input wire logic link_clk,
   input wire logic rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // bus pins
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // byte engine, ref_clk pulses
   input wire logic gen_start_done,
   input wire logic gen_stop_done,
   input wire logic cond_scl_low,
   input wire logic frame_begin,
   input wire logic data_written,
   // byte engine, link_clk level
   input wire logic tx_bit_one,
   // requests to the byte engine
   output logic start_request,
   output logic stop_request
);

   sfam_link_if lnk ();

   logic role_q, tx_q, begin_q, end_q, ack_request_flag_q, arb_q, ack_q, irq_q;
   logic [6:0] own_addr_q;
   logic gc_en_q;
   logic [6:0] mask_q;
   logic auto_ack_q;
   logic start_req_q;
   logic wr_seen_q;
   logic first_byte_q;
   logic ignore_q;
   logic addressed_q;
   logic ack_drive_q;
   logic scl_oe_q;
   logic scl_o_q;
   logic [SFAM_EV_N-1:0] ev_pulse;
   logic wr_pend_q;
   logic rd_pend_q;
   logic [7:0] addr_q;
   logic hreadyout_q;
   logic [31:0] hrdata_q;
   logic wr_ctrl, wr_own, wr_mask;
   logic e_start, e_stop, e_byte, e_ack;
   logic addr_match;
   logic slv_ok;
   logic receiving;
   logic arb_stop;
   logic arb_set;
   logic irq_set;
   logic irq_sw_clear;

   // ==========
   // link-side monitor on its own clock
   sfam_link_mon u_mon (
      .link_clk(link_clk),
      .rst(rst),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .sda_o(sda_o),
      .sda_oe(sda_oe),
      .tx_bit_one(tx_bit_one),
      .lnk(lnk.mon)
   );

   // ==========
   // toggle crossings: two sync stages, third stage for the edge
   genvar gi;
   generate
      for (gi = 0; gi < SFAM_EV_N; gi++)
      begin : g_ev
         logic [2:0] s_q;
         always_ff @(posedge ref_clk or posedge rst)
         begin
            if (rst)
               s_q <= 3'h0;
            else
               s_q <= {s_q[1:0], lnk.ev_tgl[gi]};
         end
         assign ev_pulse[gi] = s_q[2] ^ s_q[1];
      end
   endgenerate

   assign e_start = ev_pulse[SFAM_EV_START];
   assign e_stop = ev_pulse[SFAM_EV_STOP];
   assign e_byte = ev_pulse[SFAM_EV_BYTE];
   assign e_ack = ev_pulse[SFAM_EV_ACK];

   // ==========
   // AHB-Lite slave: writes zero wait, reads one wait state
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         addr_q <= 8'h00;
      end
      else if (hready)
      begin
         wr_pend_q <= hsel & htrans[1] & hwrite & (hsize == SFAM_HSIZE_WORD);
         rd_pend_q <= hsel & htrans[1] & ~hwrite;
         addr_q <= haddr[7:0];
      end
      else
         rd_pend_q <= 1'b0;
   end

   // the wait state lets a write just before a read land first
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         hreadyout_q <= 1'b1;
         hrdata_q <= 32'h0000_0000;
      end
      else if (hready && hsel && htrans[1] && !hwrite)
         hreadyout_q <= 1'b0;
      else if (rd_pend_q)
      begin
         hreadyout_q <= 1'b1;
         case (addr_q)
            SFAM_CTRL_OFS: hrdata_q <= {24'h000000, role_q, tx_q, begin_q, end_q,
                                        ack_request_flag_q, arb_q, ack_q, irq_q};
            SFAM_OWN_OFS: hrdata_q <= {24'h000000, own_addr_q, gc_en_q};
            SFAM_MASK_OFS: hrdata_q <= {24'h000000, mask_q, auto_ack_q};
            default: hrdata_q <= 32'h0000_0000;
         endcase
      end
   end

   assign wr_ctrl = wr_pend_q & (addr_q == SFAM_CTRL_OFS);
   assign wr_own = wr_pend_q & (addr_q == SFAM_OWN_OFS);
   assign wr_mask = wr_pend_q & (addr_q == SFAM_MASK_OFS);

   // ==========
   // address configuration registers
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         own_addr_q <= SFAM_OWN_ADDR_RST;
         gc_en_q <= SFAM_GC_RST;
         mask_q <= SFAM_MASK_RST;
         auto_ack_q <= SFAM_AUTO_ACK_RST;
      end
      else
      begin
         if (wr_own)
         begin
            own_addr_q <= hwdata[7:1];
            gc_en_q <= hwdata[0];
         end
         // [RULE_15] mask and auto ack
         if (wr_mask)
         begin
            mask_q <= hwdata[7:1];
            auto_ack_q <= hwdata[0];
         end
      end
   end

   // ==========
   // address match and frame context
   // [RULE_16] seven address bits
   // [RULE_11] masked compare
   // [RULE_12] general call
   // [RULE_17] no match without auto ack
   assign addr_match = auto_ack_q &
                       ((((lnk.rx_byte[7:1] ^ own_addr_q) & mask_q) == 7'h00) |
                        (gc_en_q & (lnk.rx_byte[7:1] == 7'h00)));
   // [RULE_14] silent after nack
   assign slv_ok = role_q | ~ignore_q;
   assign receiving = first_byte_q ? ~role_q : ~tx_q;

   // first byte after START is the address; addressed until STOP or START
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         first_byte_q <= 1'b0;
         ignore_q <= 1'b0;
         addressed_q <= 1'b0;
      end
      else if (e_start)
      begin
         first_byte_q <= 1'b1;
         ignore_q <= 1'b0;
         addressed_q <= 1'b0;
      end
      else
      begin
         if (e_ack)
            first_byte_q <= 1'b0;
         if (e_stop)
            addressed_q <= 1'b0;
         // [RULE_14] nack sets ignore
         if (e_byte && first_byte_q && !role_q && auto_ack_q && !addr_match)
            ignore_q <= 1'b1;
         else if (e_ack && first_byte_q && !role_q && lnk.ack_sample)
            ignore_q <= 1'b1;
         if (e_ack && first_byte_q && !role_q && !lnk.ack_sample)
            addressed_q <= 1'b1;
      end
   end

   // ==========
   // wanted ack level; crosses as a level, stable long before the slot
   // [RULE_10] hardware ack decision
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         ack_drive_q <= 1'b0;
      else
         ack_drive_q <= receiving & slv_ok &
                        ((auto_ack_q & first_byte_q & ~role_q) ? addr_match : ack_q);
   end
   assign lnk.ack_drive = ack_drive_q;

   // ==========
   // arbitration loss sources
   assign arb_stop = e_stop & role_q & ~end_q;
   // [RULE_06] any loss source
   assign arb_set = ev_pulse[SFAM_EV_ARB] | cond_scl_low | arb_stop |
                    (e_start & role_q & ~start_req_q);

   // ==========
   // controller role, start request and pending data write
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         role_q <= 1'b0;
         start_req_q <= 1'b0;
         wr_seen_q <= 1'b0;
      end
      else
      begin
         // [RULE_01] role set and clear
         if (gen_start_done)
            role_q <= 1'b1;
         else if (gen_stop_done || arb_set)
            role_q <= 1'b0;
         if (wr_ctrl && hwdata[SFAM_BEGIN_BIT])
            start_req_q <= 1'b1;
         else if (gen_start_done)
            start_req_q <= 1'b0;
         if (data_written)
            wr_seen_q <= 1'b1;
         else if (frame_begin)
            wr_seen_q <= 1'b0;
      end
   end

   // [RULE_02] transmitter set and clear
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         tx_q <= 1'b0;
      else if (gen_start_done || (frame_begin && (wr_seen_q || data_written)))
         tx_q <= 1'b1;
      else if ((e_start && !role_q) || arb_set || frame_begin)
         tx_q <= 1'b0;
   end

   // [RULE_03] begin seen, software clear
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         begin_q <= 1'b0;
      else if (e_byte && first_byte_q)
         begin_q <= 1'b1;
      else if (wr_ctrl && !hwdata[SFAM_BEGIN_BIT])
         begin_q <= 1'b0;
   end

   // [RULE_04] end condition flag
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         end_q <= 1'b0;
      else if ((e_stop && addressed_q) || arb_stop || (wr_ctrl && hwdata[SFAM_END_BIT]))
         end_q <= 1'b1;
      else if (gen_stop_done || wr_ctrl)
         end_q <= 1'b0;
   end

   // [RULE_05] ack request
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         ack_request_flag_q <= 1'b0;
      else if (e_byte && !auto_ack_q && receiving && slv_ok)
         ack_request_flag_q <= 1'b1;
      else if (e_ack)
         ack_request_flag_q <= 1'b0;
   end

   // [RULE_08] ack bit load
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         ack_q <= 1'b0;
      else if (e_ack)
         ack_q <= ~lnk.ack_sample;
      else if (wr_ctrl)
         ack_q <= hwdata[SFAM_ACK_BIT];
   end

   // ==========
   // interrupt flag: hardware set wins over a software clear
   // [RULE_09] interrupt sources
   assign irq_set = gen_start_done | arb_set |
                    (e_ack & ~receiving & slv_ok) |
                    (e_byte & receiving & slv_ok & ~auto_ack_q) |
                    (e_ack & receiving & slv_ok & auto_ack_q &
                     ~(first_byte_q & ~role_q & ~addr_match)) |
                    (e_stop & addressed_q) |
                    (wr_ctrl & hwdata[SFAM_IRQ_BIT]);
   assign irq_sw_clear = wr_ctrl & ~hwdata[SFAM_IRQ_BIT];

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         irq_q <= 1'b0;
      else if (irq_set)
         irq_q <= 1'b1;
      else if (irq_sw_clear)
         irq_q <= 1'b0;
   end

   // [RULE_07] cleared with interrupt flag
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         arb_q <= 1'b0;
      else if (arb_set)
         arb_q <= 1'b1;
      else if (irq_sw_clear)
         arb_q <= 1'b0;
   end

   // ==========
   // pin and request outputs; one cycle behind the flags
   // [RULE_13] stall while flag set
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         scl_oe_q <= 1'b0;
         scl_o_q <= 1'b0;
         start_request <= 1'b0;
         stop_request <= 1'b0;
      end
      else
      begin
         scl_oe_q <= irq_q;
         scl_o_q <= 1'b0;
         start_request <= start_req_q & ~gen_start_done;
         stop_request <= end_q & role_q & ~gen_stop_done;
      end
   end

   assign scl_oe = scl_oe_q;
   assign scl_o = scl_o_q;
   assign hreadyout = hreadyout_q;
   assign hrdata = hrdata_q;
   assign hresp = 1'b0;

endmodule

`default_nettype wire
